// >>> hw/imuod_pkg.sv
package imuod_pkg;

	// ****************************************************************
	// Register offsets (byte addresses on the serial port)
	// ****************************************************************
	localparam logic [6:0] ADDR_Z_RATE_LOW_WORD       = 7'h18;
	localparam logic [6:0] ADDR_Z_RATE_HIGH_WORD      = 7'h1A;
	localparam logic [6:0] ADDR_X_ACCEL_LOW_WORD      = 7'h1C;
	localparam logic [6:0] ADDR_X_ACCEL_HIGH_WORD     = 7'h1E;
	localparam logic [6:0] ADDR_Y_ACCEL_LOW_WORD      = 7'h20;
	localparam logic [6:0] ADDR_Y_ACCEL_HIGH_WORD     = 7'h22;
	localparam logic [6:0] ADDR_Z_ACCEL_LOW_WORD      = 7'h24;
	localparam logic [6:0] ADDR_Z_ACCEL_HIGH_WORD     = 7'h26;
	localparam logic [6:0] ADDR_PULSE_REL_SAMPLE_TIME = 7'h28;
	localparam logic [6:0] ADDR_CHECKSUM_LOWER_WORD   = 7'h2A;
	localparam logic [6:0] ADDR_CHECKSUM_UPPER_WORD   = 7'h2C;
	localparam logic [6:0] ADDR_X_ANGLE_INC_LOW       = 7'h40;
	localparam logic [6:0] ADDR_X_ANGLE_INC_HIGH      = 7'h42;

	// ****************************************************************
	// Field positions, reset values, modes
	// ****************************************************************
	localparam int          WORD_W          = 16;
	localparam int          FRAME_LAST_BIT  = 15;
	localparam int          CMD_READ_BIT    = 15;
	localparam int          CMD_ADDR_HI     = 14;
	localparam int          CMD_ADDR_LO     = 8;
	localparam logic [1:0]  CLK_MODE_PULSE  = 2'b11;
	localparam logic [15:0] TIME_RESET      = 16'h0000;
	localparam logic [15:0] WORD_UNMAPPED   = 16'h0000;
	localparam logic [15:0] GROUP_FIRST     = 16'h0000;

	// ****************************************************************
	// Checksum engine
	// ****************************************************************
	localparam logic [31:0] CRC_POLY        = 32'h04C11DB7;
	localparam logic [31:0] CRC_INIT        = 32'hFFFFFFFF;
	localparam logic [3:0]  CRC_LAST_WORD   = 4'hE;

	// ****************************************************************
	// Delta angle scaling (default for the smallest range variant)
	// ****************************************************************
	localparam int          DANG_RANGE_DEG_V1 = 360;
	localparam int          DANG_RANGE_DEG_V2 = 720;
	localparam int          DANG_RANGE_DEG_V3 = 2160;
	localparam logic [31:0] DANG_MULT_V1      = 32'h000462DA;
	localparam int          DANG_SHIFT        = 32;

	// ****************************************************************
	// Types
	// ****************************************************************
	typedef enum logic [1:0]
	{
		CRC_IDLE = 2'b00,
		CRC_RUN  = 2'b01,
		CRC_DONE = 2'b10
	} imuod_crc_state_t;

	typedef struct packed
	{
		logic [15:0]        error_flags;
		logic [15:0]        temperature;
		logic signed [31:0] rate_x;
		logic signed [31:0] rate_y;
		logic signed [31:0] rate_z;
		logic signed [31:0] accel_x;
		logic signed [31:0] accel_y;
		logic signed [31:0] accel_z;
	} imuod_sample_t;

	typedef struct packed
	{
		imuod_sample_t      sample;
		logic [15:0]        sample_time;
		logic signed [31:0] angle_inc_x;
	} imuod_snap_t;

endpackage

// >>> hw/imuod_crc_engine.sv
`timescale 1ns/1ps
`default_nettype none

// Checksum over one 16-bit word per clock, MSB first
module imuod_crc_engine
(
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        nrst,
	input  wire logic        ce,
	// Word stream
	input  wire logic        crc_init,
	input  wire logic        word_valid,
	input  wire logic [15:0] word,
	// Result
	output logic      [31:0] crc
);

	logic [31:0] chain [0:16];

	// One shift stage per data bit
	assign chain[0] = crc;
	genvar b;
	generate
		for (b = 0; b < 16; b++)
		begin : g_bit
			assign chain[b + 1] = chain[b][31] ^ word[15 - b]
				? {chain[b][30:0], 1'b0} ^ imuod_pkg::CRC_POLY
				: {chain[b][30:0], 1'b0};
		end
	endgenerate

	// Register holding the running remainder
	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
			crc <= imuod_pkg::CRC_INIT;
		else if (ce)
		begin
			if (crc_init)
				crc <= imuod_pkg::CRC_INIT;
			else if (word_valid)
				crc <= chain[16];
		end
	end

endmodule

`default_nettype wire

// >>> hw/imuod_output_regs.sv
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Accel high word: signed, zero g reads 0x0000, 0.25 mg per count.
// - Each accel axis has low and high words forming one 32-bit value.
// - Z rate: low word holds extra resolution, high word signed, zero reads 0.
// - In pulse clock mode 11, sample time spans last sync pulse to update.
// - Sample time is 16-bit sample count, cleared on sync leading edge.
// - With decimation, sample time shows first raw sample of each group.
// - Checksum covers flags, temperature, rates, accels, sample time, in order.
// - Checksum lower and upper halves sit in two read-only registers.
// - Delta angle sums rate plus previous rate over D samples, scaled.
// - Integration rate is the raw sample rate, internal or external clock.
// - Full-scale delta angle is 360, 720 or 2160 degrees by variant.
// - Delta angle low and high words form one signed 32-bit value.
// - Delta angle high word count equals full scale over two to fifteen.
module imuod_output_regs
#(
	parameter logic [31:0] DANG_MULT = imuod_pkg::DANG_MULT_V1
)
(
	// Clock, reset, enable
	input  wire logic                     sys_clk,
	input  wire logic                     nrst,
	input  wire logic                     ce,
	// Sensor core, same clock domain
	input  wire logic                     sample_strobe,
	input  wire imuod_pkg::imuod_sample_t sample,
	input  wire logic [1:0]               clock_mode,
	input  wire logic [15:0]              decimation_setting,
	// Device pins
	input  wire logic                     sync_pin,
	input  wire logic                     spi_cs_n,
	input  wire logic                     spi_sclk,
	input  wire logic                     spi_mosi,
	output logic                          spi_miso,
	output logic                          data_ready
);

	// ****************************************************************
	// Pin synchronisers
	// ****************************************************************
	logic [2:0] sync_s;
	logic [2:0] sclk_s;
	logic [2:0] cs_s;
	logic [1:0] mosi_s;

	// Two flops before use; third flop only feeds edge detection
	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			sync_s <= 3'h0;
			sclk_s <= 3'h7;
			cs_s   <= 3'h7;
			mosi_s <= 2'h0;
		end
		else if (ce)
		begin
			sync_s <= {sync_s[1:0], sync_pin};
			sclk_s <= {sclk_s[1:0], spi_sclk};
			cs_s   <= {cs_s[1:0], spi_cs_n};
			mosi_s <= {mosi_s[0], spi_mosi};
		end
	end

	logic sync_edge;
	logic sclk_rise;
	logic sclk_fall;
	logic cs_fall;
	logic pulse_mode;

	assign pulse_mode = (clock_mode == imuod_pkg::CLK_MODE_PULSE);
	assign sync_edge  = pulse_mode && sync_s[1] && !sync_s[2];
	assign sclk_rise  = sclk_s[1] && !sclk_s[2] && !cs_s[1];
	assign sclk_fall  = !sclk_s[1] && sclk_s[2] && !cs_s[1];
	assign cs_fall    = !cs_s[1] && cs_s[2];

	// ****************************************************************
	// Decimation group and sample time
	// ****************************************************************
	logic [15:0] grp_cnt;
	logic [15:0] time_cnt;
	logic [15:0] first_time;
	logic [15:0] next_time_cnt;
	logic        update;
	logic [15:0] grp_pos;

	// A raw sample arriving with the sync edge counts as the first after it
	assign next_time_cnt = sync_edge ? 16'h0001 : time_cnt + 16'h0001;
	assign grp_pos = sync_edge ? imuod_pkg::GROUP_FIRST : grp_cnt;
	assign update  = sample_strobe && grp_pos == decimation_setting;

	// Group position; a sync edge restarts the group
	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
			grp_cnt <= imuod_pkg::GROUP_FIRST;
		else if (ce)
		begin
			if (sample_strobe)
				grp_cnt <= update ? imuod_pkg::GROUP_FIRST : grp_pos + 16'h0001;
			else if (sync_edge)
				grp_cnt <= imuod_pkg::GROUP_FIRST;
		end
	end

	// Samples since the last sync leading edge
	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
			time_cnt <= imuod_pkg::TIME_RESET;
		else if (ce)
		begin
			if (!pulse_mode)
				time_cnt <= imuod_pkg::TIME_RESET;
			else if (sample_strobe)
				time_cnt <= next_time_cnt;
			else if (sync_edge)
				time_cnt <= imuod_pkg::TIME_RESET;
		end
	end

	// Time of first raw sample in the group
	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
			first_time <= imuod_pkg::TIME_RESET;
		else if (ce && sample_strobe && grp_pos == imuod_pkg::GROUP_FIRST)
			first_time <= pulse_mode ? next_time_cnt : imuod_pkg::TIME_RESET;
	end

	// ****************************************************************
	// Delta angle integration, x axis
	// ****************************************************************
	logic signed [31:0] prev_rate_x;
	logic signed [49:0] angle_acc;
	logic signed [49:0] angle_sum;
	logic signed [32:0] mult_s;
	logic signed [82:0] angle_prod;
	logic signed [31:0] angle_scaled;

	// Trapezoid term; the first of a group starts a fresh sum
	always_comb
	begin
		angle_sum = (grp_pos == imuod_pkg::GROUP_FIRST ? 50'sh0 : angle_acc)
			+ 50'(sample.rate_x) + 50'(prev_rate_x);
	end

	// Scale carries 1/(2 fs) and the variant range into output counts
	assign mult_s       = $signed({1'b0, DANG_MULT});
	assign angle_prod   = angle_sum * mult_s;
	assign angle_scaled = 32'(angle_prod >>> imuod_pkg::DANG_SHIFT);

	// Running sum and previous raw rate
	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			angle_acc   <= 50'sh0;
			prev_rate_x <= 32'sh0;
		end
		else if (ce && sample_strobe)
		begin
			angle_acc   <= angle_sum;
			prev_rate_x <= sample.rate_x;
		end
	end

	// ****************************************************************
	// Coherent snapshot of all outputs except the checksum, which is published after its fifteen words
	// ****************************************************************
	imuod_pkg::imuod_snap_t snap;

	// Whole set latched at once so word pairs never tear
	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			snap       <= '0;
			data_ready <= 1'b0;
		end
		else if (ce)
		begin
			data_ready <= update;
			if (update)
			begin
				snap.sample      <= sample;
				snap.sample_time <= grp_pos == imuod_pkg::GROUP_FIRST && pulse_mode
					? next_time_cnt : first_time;
				snap.angle_inc_x <= angle_scaled;
			end
		end
	end

	// ****************************************************************
	// Checksum sequencing
	// ****************************************************************
	imuod_pkg::imuod_crc_state_t crc_state;
	logic [3:0]                  crc_idx;
	logic [15:0]                 crc_word;
	logic [31:0]                 crc_val;
	logic [31:0]                 crc_reg;

	// Word order of the checksum
	always_comb
	begin
		case (crc_idx)
			4'h0:    crc_word = snap.sample.error_flags;
			4'h1:    crc_word = snap.sample.temperature;
			4'h2:    crc_word = snap.sample.rate_x[15:0];
			4'h3:    crc_word = snap.sample.rate_x[31:16];
			4'h4:    crc_word = snap.sample.rate_y[15:0];
			4'h5:    crc_word = snap.sample.rate_y[31:16];
			4'h6:    crc_word = snap.sample.rate_z[15:0];
			4'h7:    crc_word = snap.sample.rate_z[31:16];
			4'h8:    crc_word = snap.sample.accel_x[15:0];
			4'h9:    crc_word = snap.sample.accel_x[31:16];
			4'hA:    crc_word = snap.sample.accel_y[15:0];
			4'hB:    crc_word = snap.sample.accel_y[31:16];
			4'hC:    crc_word = snap.sample.accel_z[15:0];
			4'hD:    crc_word = snap.sample.accel_z[31:16];
			4'hE:    crc_word = snap.sample_time;
			default: crc_word = imuod_pkg::WORD_UNMAPPED;
		endcase
	end

	imuod_crc_engine u_crc
	(
		.sys_clk    (sys_clk),
		.nrst       (nrst),
		.ce         (ce),
		.crc_init   (update),
		.word_valid (crc_state == imuod_pkg::CRC_RUN),
		.word       (crc_word),
		.crc        (crc_val)
	);

	// Feeds fifteen words, then publishes; a new update restarts it
	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			crc_state <= imuod_pkg::CRC_IDLE;
			crc_idx   <= 4'h0;
			crc_reg   <= 32'h0;
		end
		else if (ce)
		begin
			if (update)
			begin
				crc_state <= imuod_pkg::CRC_RUN;
				crc_idx   <= 4'h0;
			end
			else
			begin
				case (crc_state)
					imuod_pkg::CRC_RUN:
					begin
						crc_idx <= crc_idx + 4'h1;
						if (crc_idx == imuod_pkg::CRC_LAST_WORD)
							crc_state <= imuod_pkg::CRC_DONE;
					end
					imuod_pkg::CRC_DONE:
					begin
						crc_reg   <= crc_val;
						crc_state <= imuod_pkg::CRC_IDLE;
					end
					default:
						crc_state <= imuod_pkg::CRC_IDLE;
				endcase
			end
		end
	end

	// ****************************************************************
	// Register read mux
	// ****************************************************************
	logic [6:0]  rd_addr;
	logic [15:0] rd_data;

	always_comb
	begin
		case (rd_addr)
			imuod_pkg::ADDR_Z_RATE_LOW_WORD:       rd_data = snap.sample.rate_z[15:0];
			imuod_pkg::ADDR_Z_RATE_HIGH_WORD:      rd_data = snap.sample.rate_z[31:16];
			imuod_pkg::ADDR_X_ACCEL_LOW_WORD:      rd_data = snap.sample.accel_x[15:0];
			imuod_pkg::ADDR_X_ACCEL_HIGH_WORD:     rd_data = snap.sample.accel_x[31:16];
			imuod_pkg::ADDR_Y_ACCEL_LOW_WORD:      rd_data = snap.sample.accel_y[15:0];
			imuod_pkg::ADDR_Y_ACCEL_HIGH_WORD:     rd_data = snap.sample.accel_y[31:16];
			imuod_pkg::ADDR_Z_ACCEL_LOW_WORD:      rd_data = snap.sample.accel_z[15:0];
			imuod_pkg::ADDR_Z_ACCEL_HIGH_WORD:     rd_data = snap.sample.accel_z[31:16];
			imuod_pkg::ADDR_PULSE_REL_SAMPLE_TIME: rd_data = snap.sample_time;
			imuod_pkg::ADDR_CHECKSUM_LOWER_WORD:   rd_data = crc_reg[15:0];
			imuod_pkg::ADDR_CHECKSUM_UPPER_WORD:   rd_data = crc_reg[31:16];
			imuod_pkg::ADDR_X_ANGLE_INC_LOW:       rd_data = snap.angle_inc_x[15:0];
			imuod_pkg::ADDR_X_ANGLE_INC_HIGH:      rd_data = snap.angle_inc_x[31:16];
			default:                               rd_data = imuod_pkg::WORD_UNMAPPED;
		endcase
	end

	// ****************************************************************
	// Serial port slave, mode 3, 16-bit frames
	// ****************************************************************
	logic [15:0] rx_sh;
	logic [15:0] tx_sh;
	logic [15:0] resp;
	logic [3:0]  bit_cnt;
	logic [15:0] rx_full;

	// Answer to a read appears in the following frame
	assign rx_full = {rx_sh[14:0], mosi_s[1]};
	assign rd_addr = {rx_full[imuod_pkg::CMD_ADDR_HI:imuod_pkg::CMD_ADDR_LO + 1], 1'b0};

	// Receive on rising clock, decode at the last bit
	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			rx_sh   <= 16'h0000;
			bit_cnt <= 4'h0;
			resp    <= 16'h0000;
		end
		else if (ce)
		begin
			if (cs_fall)
				bit_cnt <= 4'h0;
			else if (sclk_rise)
			begin
				rx_sh   <= rx_full;
				bit_cnt <= bit_cnt + 4'h1;
				if (bit_cnt == 4'(imuod_pkg::FRAME_LAST_BIT))
					resp <= rx_full[imuod_pkg::CMD_READ_BIT]
						? imuod_pkg::WORD_UNMAPPED : rd_data;
			end
		end
	end

	// Transmit: first bit at select, next ones on falling clock
	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			tx_sh    <= 16'h0000;
			spi_miso <= 1'b0;
		end
		else if (ce)
		begin
			if (cs_fall)
			begin
				spi_miso <= resp[15];
				tx_sh    <= {resp[14:0], 1'b0};
			end
			else if (sclk_fall)
			begin
				spi_miso <= tx_sh[15];
				tx_sh    <= {tx_sh[14:0], 1'b0};
			end
		end
	end

endmodule

`default_nettype wire

// >>> sim/imuod_monitor.sv
`timescale 1ns/1ps
`default_nettype none

// ********
// Port checker for the output registers
// ********
module imuod_monitor
(
	// Clock and reset
	input wire logic        sys_clk,
	input wire logic        nrst,
	input wire logic        ce,
	// Sensor side
	input wire logic        sample_strobe,
	input wire logic [1:0]  clock_mode,
	input wire logic [15:0] decimation_setting,
	// Serial port and flag
	input wire logic        spi_cs_n,
	input wire logic        spi_sclk,
	input wire logic        spi_miso,
	input wire logic        data_ready
);
	logic [15:0] grp;
	logic        grp_ok;
	logic        framed;
	logic        take;

	default clocking mon_cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);

	// Own group count; a sync may restart the group, so pulse mode is left out
	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			grp    <= 16'h0000;
			grp_ok <= 1'b1;
		end
		else
		begin
			if (clock_mode == 2'b11)
				grp_ok <= 1'b0;
			if (ce && sample_strobe)
				grp <= (grp == decimation_setting) ? 16'h0000 : grp + 16'h0001;
		end
	end

	// Remembers that a frame has been seen since reset
	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
			framed <= 1'b0;
		else if (!spi_cs_n)
			framed <= 1'b1;
	end

	// Strobe that the block accepts outside pulse mode
	assign take = ce && sample_strobe && grp_ok && clock_mode != 2'b11;

	chk_ready_single: assert property (data_ready && decimation_setting != 16'h0000 |=> !data_ready)
		else $error("Update flag held two cycles");
	chk_ready_cause: assert property (data_ready |-> $past(sample_strobe && ce))
		else $error("Update flag without a strobe");
	chk_group_end: assert property (take && grp == decimation_setting |=> data_ready)
		else $error("No update at end of group");
	chk_group_quiet: assert property (take && grp != decimation_setting |=> !data_ready)
		else $error("Update inside a group");
	chk_ce_freeze: assert property (!ce |=> $stable(spi_miso) && $stable(data_ready))
		else $error("Outputs moved while disabled");
	chk_miso_steady: assert property (!spi_cs_n && $rose(spi_sclk) |-> $stable(spi_miso) [*4])
		else $error("Data out moved while clock high");
	chk_miso_deselect: assert property (spi_cs_n [*6] |-> $stable(spi_miso))
		else $error("Data out moved while deselected");
	chk_miso_quiet: assert property (!framed && spi_cs_n |-> !spi_miso)
		else $error("Data out high before any frame");
endmodule

bind imuod_output_regs imuod_monitor i_mon
(
	.sys_clk(sys_clk),
	.nrst(nrst),
	.ce(ce),
	.sample_strobe(sample_strobe),
	.clock_mode(clock_mode),
	.decimation_setting(decimation_setting),
	.spi_cs_n(spi_cs_n),
	.spi_sclk(spi_sclk),
	.spi_miso(spi_miso),
	.data_ready(data_ready)
);

`default_nettype wire

// >>> sim/imuod_host_model.sv
`timescale 1ns/1ps
`default_nettype none

// ********
// Serial port master in the host's place
// ********
module imuod_host_model
(
	// Bench clock
	input  wire logic sys_clk,
	// Serial port pins
	output var logic  spi_cs_n,
	output var logic  spi_sclk,
	output var logic  spi_mosi,
	input  wire logic spi_miso
);
	// Half period of the 160 ns link clock, in system clocks
	localparam int HALF = 4;

	// Deselected, clock parked high
	initial
	begin
		spi_cs_n = 1'b1;
		spi_sclk = 1'b1;
		spi_mosi = 1'b0;
	end

	// One frame, MSB first; pins move on system clock edges only
	task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
		spi_cs_n <= 1'b0;
		repeat (HALF) @(posedge sys_clk);
		for (int i = 15; i >= 0; i--)
		begin
			// Bit was put out after select or the previous falling edge
			rx[i] = spi_miso;
			spi_sclk <= 1'b0;
			spi_mosi <= tx[i];
			repeat (HALF) @(posedge sys_clk);
			spi_sclk <= 1'b1;
			repeat (HALF) @(posedge sys_clk);
		end
		// Released line flips so a stale bit is never mistaken for data
		spi_cs_n <= 1'b1;
		spi_mosi <= ~spi_mosi;
		repeat (2 * HALF) @(posedge sys_clk);
	endtask
endmodule

`default_nettype wire

// >>> sim/tb.sv
`timescale 1ns/1ps
`default_nettype none

// ********
// Bench for the output registers
// ********
module tb;
	logic                     sys_clk;
	logic                     nrst;
	logic                     ce;
	logic                     sample_strobe;
	imuod_pkg::imuod_sample_t sample;
	logic [1:0]               clock_mode;
	logic [15:0]              decimation_setting;
	logic                     sync_pin;
	logic                     spi_cs_n;
	logic                     spi_sclk;
	logic                     spi_mosi;
	logic                     spi_miso;
	logic                     data_ready;
	int                       n_fail;
	int                       checks_done;
	logic [15:0]              got;

	imuod_output_regs i_dut
	(
		.sys_clk(sys_clk),
		.nrst(nrst),
		.ce(ce),
		.sample_strobe(sample_strobe),
		.sample(sample),
		.clock_mode(clock_mode),
		.decimation_setting(decimation_setting),
		.sync_pin(sync_pin),
		.spi_cs_n(spi_cs_n),
		.spi_sclk(spi_sclk),
		.spi_mosi(spi_mosi),
		.spi_miso(spi_miso),
		.data_ready(data_ready)
	);

	imuod_host_model i_host
	(
		.sys_clk(sys_clk),
		.spi_cs_n(spi_cs_n),
		.spi_sclk(spi_sclk),
		.spi_mosi(spi_mosi),
		.spi_miso(spi_miso)
	);

	// 50 MHz clock
	initial
	begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end

	// Compare and count
	task automatic check(input logic [15:0] seen, input logic [15:0] want);
		checks_done++;
		if (seen !== want)
		begin
			n_fail++;
			$display("BAD t=%0t seen=%h want=%h", $time, seen, want);
		end
	endtask

	// Verdict
	task automatic stop_test();
		if (n_fail == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// Configuration only changes under reset, so groups start clean
	task automatic restart(input logic [1:0] mode, input logic [15:0] dec);
		nrst <= 1'b0;
		clock_mode <= mode;
		decimation_setting <= dec;
		repeat (20) @(posedge sys_clk);
		nrst <= 1'b1;
		repeat (3) @(posedge sys_clk);
	endtask

	// One raw sample; en low shows a strobe the block must ignore
	task automatic strobe(input logic en);
		ce <= en;
		sample_strobe <= 1'b1;
		@(posedge sys_clk);
		ce <= 1'b1;
		sample_strobe <= 1'b0;
		@(posedge sys_clk);
	endtask

	// Sync pulse on the pin
	task automatic pulse();
		sync_pin <= 1'b1;
		repeat (4) @(posedge sys_clk);
		sync_pin <= 1'b0;
		repeat (4) @(posedge sys_clk);
	endtask

	// Answer rides on the next frame, whose own read is outside the block
	task automatic read_word(input logic [6:0] addr, output logic [15:0] val);
		logic [15:0] unused;
		i_host.xfer({1'b0, addr, 8'h00}, unused);
		i_host.xfer(16'h0000, val);
	endtask

	// Checksum, MSB first, no reflection, no final inversion
	function automatic logic [31:0] crc_of(input imuod_pkg::imuod_sample_t s,
		input logic [15:0] t);
		logic [15:0] w [15];
		logic [31:0] c;
		w = '{s.error_flags, s.temperature, s.rate_x[15:0], s.rate_x[31:16],
			s.rate_y[15:0], s.rate_y[31:16], s.rate_z[15:0], s.rate_z[31:16],
			s.accel_x[15:0], s.accel_x[31:16], s.accel_y[15:0], s.accel_y[31:16],
			s.accel_z[15:0], s.accel_z[31:16], t};
		c = imuod_pkg::CRC_INIT;
		foreach (w[i])
			for (int b = 15; b >= 0; b--)
				c = {c[30:0], 1'b0} ^ ((c[31] ^ w[i][b]) ? imuod_pkg::CRC_POLY : 32'h0);
		return c;
	endfunction

	// Trapezoid sum scaled: keep the top half of the product
	function automatic logic [31:0] dang(input longint sum);
		longint p;
		p = sum * longint'(imuod_pkg::DANG_MULT_V1);
		return p[63:32];
	endfunction

	// Update after two strobes: words, checksum, angle, unmapped read, ignored write
	task automatic scen_snapshot();
		imuod_pkg::imuod_sample_t s;
		logic [15:0] want [11];
		logic [31:0] crc;
		logic [31:0] ang;
		s = '{error_flags: 16'h0000, temperature: 16'h083A, rate_x: 32'h2000_0000,
			rate_y: 32'hFFFE_0000, rate_z: 32'h0001_8001, accel_x: 32'h0003_5001,
			accel_y: 32'hFFEB_E00A, accel_z: 32'h0320_C009};
		restart(2'b00, 16'h0001);
		sample <= s;
		strobe(1'b1);
		strobe(1'b1);
		crc = crc_of(s, imuod_pkg::TIME_RESET);
		ang = dang(3 * longint'(s.rate_x));
		want = '{s.rate_z[15:0], s.rate_z[31:16], s.accel_x[15:0], s.accel_x[31:16],
			s.accel_y[15:0], s.accel_y[31:16], s.accel_z[15:0], s.accel_z[31:16],
			imuod_pkg::TIME_RESET, crc[15:0], crc[31:16]};
		foreach (want[i])
		begin
			read_word(imuod_pkg::ADDR_Z_RATE_LOW_WORD + 7'(2 * i), got);
			check(got, want[i]);
		end
		read_word(imuod_pkg::ADDR_X_ANGLE_INC_LOW, got);
		check(got, ang[15:0]);
		read_word(imuod_pkg::ADDR_X_ANGLE_INC_HIGH, got);
		check(got, ang[31:16]);
		read_word(7'h30, got);
		check(got, imuod_pkg::WORD_UNMAPPED);
		i_host.xfer({1'b1, imuod_pkg::ADDR_Z_ACCEL_HIGH_WORD, 8'h55}, got);
		i_host.xfer(16'h0000, got);
		check(got, 16'h0000);
		read_word(imuod_pkg::ADDR_Z_ACCEL_HIGH_WORD, got);
		check(got, s.accel_z[31:16]);
	endtask

	// Pulse mode, groups of four; disabled strobe must not count
	task automatic scen_sync();
		imuod_pkg::imuod_sample_t s;
		logic [31:0] ang;
		s = '0;
		s.rate_x = -32'sh0100_0000;
		restart(2'b11, 16'h0003);
		sample <= s;
		ang = dang(7 * longint'(s.rate_x));
		pulse();
		for (int g = 0; g < 3; g++)
		begin
			if (g == 1)
				strobe(1'b0);
			repeat (4) strobe(1'b1);
			read_word(imuod_pkg::ADDR_PULSE_REL_SAMPLE_TIME, got);
			check(got, 16'(1 + 4 * g));
			if (g == 0)
			begin
				read_word(imuod_pkg::ADDR_X_ANGLE_INC_LOW, got);
				check(got, ang[15:0]);
				read_word(imuod_pkg::ADDR_X_ANGLE_INC_HIGH, got);
				check(got, ang[31:16]);
			end
		end
		pulse();
		repeat (4) strobe(1'b1);
		read_word(imuod_pkg::ADDR_PULSE_REL_SAMPLE_TIME, got);
		check(got, 16'h0001);
	endtask

	// Main sequence
	initial
	begin
		n_fail = 0;
		checks_done = 0;
		nrst = 1'b0;
		ce = 1'b1;
		sample_strobe = 1'b0;
		sample = '0;
		clock_mode = 2'b00;
		decimation_setting = 16'h0000;
		sync_pin = 1'b0;
		@(posedge sys_clk);
		scen_snapshot();
		scen_sync();
		stop_test();
	end

	// Watchdog at about three times the expected run of some 6300 clocks
	initial
	begin
		#400000;
		n_fail++;
		stop_test();
	end
endmodule

`default_nettype wire
